// [hw/asc_ctrl.sv]
// host controller that sequences read and write cycles on an async static memory
`timescale 1ns/1ps
module asc_ctrl (
  input  wire logic            core_clk,
  input  wire logic            nrst,
  input  asc_pkg::asc_req_s    req,
  output logic                 req_ready,
  output logic [3:0]           rd_data,
  output logic                 rd_valid,
  output asc_pkg::asc_pins_s   mem_pins,
  input  wire logic [3:0]      shared_data_lines_in
);
  import asc_pkg::*;

  asc_regs_s   r;
  asc_regs_s   next_r;
  logic        take;
  logic        take_rd;
  logic        take_wr;
  logic        cnt_last;
  logic [3:0]  line_seen;

  // last cycle of a timed phase; at 100 ns every phase is a single cycle
  function automatic logic timer_done(
    input logic [3:0] cnt
  );
    timer_done = (cnt <= 4'h1);
  endfunction : timer_done

  function automatic logic [3:0] timer_step(
    input logic [3:0] cnt
  );
    timer_step = cnt - 4'h1;
  endfunction : timer_step

  // counts loaded on entry to each timed phase
  function automatic logic [3:0] phase_count(
    input asc_state_e s
  );
    case (s)
      ASC_RD_ACC:   phase_count = ACCESS_CLK;
      ASC_RD_DONE:  phase_count = HIZ_CLK;
      ASC_WR_PULSE: phase_count = WRITE_PW_CLK;
      ASC_WR_REC:   phase_count = WRITE_CYC_CLK;
      default:      phase_count = 4'h1;
    endcase
  endfunction : phase_count

  // the only pin set in which the memory drives the shared lines
  function automatic logic mem_reading(
    input asc_pins_s p
  );
    mem_reading = !p.cs_n && !p.oe_n && p.we_n;
  endfunction : mem_reading

  // drivers masked whenever the memory could be driving as well
  function automatic logic [3:0] drive_mask(
    input asc_pins_s p
  );
    drive_mask = mem_reading(p) ? 4'h0 : 4'hF;
  endfunction : drive_mask

  // deselect: strobes high and drivers off; address and data are kept
  function automatic asc_pins_s pins_release(
    input asc_pins_s p
  );
    asc_pins_s q;
    q            = p;
    q.cs_n       = 1'b1;
    q.we_n       = 1'b1;
    q.oe_n       = 1'b1;
    q.data_oe    = 4'h0;
    pins_release = q;
  endfunction : pins_release

  // select with the gate low and the strobe high; drivers stay off
  function automatic asc_pins_s launch_read(
    input asc_pins_s   p,
    input logic [19:0] addr
  );
    asc_pins_s q;
    q              = pins_release(p);
    q.word_address = addr;
    q.cs_n         = 1'b0;
    q.we_n         = 1'b1;
    q.oe_n         = 1'b0;
    launch_read    = q;
  endfunction : launch_read

  // address and data value set with the select; drivers stay off and the gate stays high
  function automatic asc_pins_s launch_write(
    input asc_pins_s   p,
    input logic [19:0] addr,
    input logic [3:0]  data
  );
    asc_pins_s q;
    q              = pins_release(p);
    q.word_address = addr;
    q.data_out     = data;
    q.cs_n         = 1'b0;
    q.oe_n         = 1'b1;
    launch_write   = q;
  endfunction : launch_write

  // strobe and select rise together; data and address stay for the hold
  function automatic asc_pins_s end_write(
    input asc_pins_s p
  );
    asc_pins_s q;
    q         = p;
    q.we_n    = 1'b1;
    q.cs_n    = 1'b1;
    end_write = q;
  endfunction : end_write

  assign req_ready = (r.state == ASC_IDLE);
  assign rd_data   = r.rdata;
  assign rd_valid  = r.rvalid;
  assign mem_pins  = r.pins;

  // a request is taken on the edge where valid meets ready
  assign take     = req.valid && req_ready;
  assign take_rd  = take && !req.write;
  assign take_wr  = take && req.write;
  assign cnt_last = timer_done(r.cnt);

  // a line is taken only while the memory is the one driving it
  for (genvar i = 0; i < DATA_W; i++) begin : g_line
    assign line_seen[i] = (mem_reading(r.pins) && !r.pins.data_oe[i])
                          ? shared_data_lines_in[i] : r.rdata[i];
  end

  always_comb begin
    next_r        = r;
    next_r.rvalid = 1'b0;
    case (r.state)
      ASC_IDLE: begin
        // no refresh and no background traffic; only requests make cycles
        next_r.pins = pins_release(r.pins);
        if (take_rd) begin
          next_r.pins  = launch_read(r.pins, req.addr);
          next_r.cnt   = phase_count(ASC_RD_ACC);
          next_r.state = ASC_RD_ACC;
        end else if (take_wr) begin
          next_r.pins  = launch_write(r.pins, req.addr, req.wdata);
          next_r.state = ASC_WR_SETUP;
        end
      end

      ASC_RD_ACC: begin
        if (!cnt_last) begin
          next_r.cnt = timer_step(r.cnt);
        end else begin
          // sampled after the access time, which also covers the cycle time
          next_r.rdata  = line_seen;
          next_r.rvalid = 1'b1;
          next_r.pins   = pins_release(r.pins);
          next_r.cnt    = phase_count(ASC_RD_DONE);
          next_r.state  = ASC_RD_DONE;
        end
      end

      ASC_RD_DONE: begin
        // memory turn-off waited out before anyone may drive
        if (!cnt_last) begin
          next_r.cnt = timer_step(r.cnt);
        end else begin
          next_r.state = ASC_IDLE;
        end
      end

      ASC_WR_SETUP: begin
        // strobe falls after select and address: the write starts here
        next_r.pins.we_n    = 1'b0;
        // gate high keeps the memory off, so drive with the strobe
        next_r.pins.data_oe = drive_mask(next_r.pins);
        next_r.cnt          = phase_count(ASC_WR_PULSE);
        next_r.state        = ASC_WR_PULSE;
      end

      ASC_WR_PULSE: begin
        next_r.pins.data_oe = drive_mask(r.pins);
        if (!cnt_last) begin
          next_r.cnt = timer_step(r.cnt);
        end else begin
          // one full cycle low is far above either pulse width
          next_r.pins  = end_write(next_r.pins);
          next_r.cnt   = phase_count(ASC_WR_REC);
          next_r.state = ASC_WR_REC;
        end
      end

      ASC_WR_REC: begin
        // data held a cycle past the write end, above the zero hold
        next_r.pins.data_oe = 4'h0;
        if (!cnt_last) begin
          next_r.cnt = timer_step(r.cnt);
        end else begin
          // address free to change now cycle spacing kept
          next_r.state = ASC_IDLE;
        end
      end

      default: begin
        next_r.state = ASC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      r.state             <= ASC_IDLE;
      r.cnt               <= 4'h0;
      r.pins.word_address <= ADDR_RST;
      r.pins.cs_n         <= 1'b1;
      r.pins.we_n         <= 1'b1;
      r.pins.oe_n         <= 1'b1;
      r.pins.data_out     <= DATA_RST;
      r.pins.data_oe      <= 4'h0;
      r.rdata             <= DATA_RST;
      r.rvalid            <= 1'b0;
    end else begin
      r <= next_r;
    end
  end
endmodule : asc_ctrl

// [pkg/asc_pkg.sv]
// package for the host-side controller of an asynchronous 1M x 4 static memory
package asc_pkg;
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          ADDR_W        = 20;
  localparam int          DATA_W        = 4;
  localparam int          READ_CYC_NS   = 10;
  localparam int          ACCESS_NS     = 10;
  localparam int          WRITE_CYC_NS  = 10;
  localparam int          WRITE_PW_NS   = 10;
  localparam int          HIZ_NS        = 5;
  localparam int          CNT_W         = 4;
  localparam logic [3:0]  READ_CYC_CLK  =
    4'((READ_CYC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  ACCESS_CLK    =
    4'((ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  WRITE_PW_CLK  =
    4'((WRITE_PW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  WRITE_CYC_CLK =
    4'((WRITE_CYC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  HIZ_CLK       =
    4'((HIZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [19:0] ADDR_RST      = 20'h00000;
  localparam logic [3:0]  DATA_RST      = 4'h0;

  typedef enum logic [2:0] {
    ASC_IDLE, ASC_RD_ACC, ASC_RD_DONE, ASC_WR_SETUP, ASC_WR_PULSE, ASC_WR_REC
  } asc_state_e;

  typedef struct packed {
    logic             valid;
    logic             write;
    logic [19:0]      addr;
    logic [3:0]       wdata;
  } asc_req_s;

  typedef struct packed {
    logic [19:0]      word_address;
    logic             cs_n;
    logic             we_n;
    logic             oe_n;
    logic [3:0]       data_out;
    logic [3:0]       data_oe;
  } asc_pins_s;

  typedef struct packed {
    asc_state_e       state;
    logic [3:0]       cnt;
    asc_pins_s        pins;
    logic [3:0]       rdata;
    logic             rvalid;
  } asc_regs_s;
endpackage : asc_pkg

// [sim/asc_chk.sv]
// checker on the memory controller pins
`timescale 1ns/1ps
module asc_chk (
  input wire logic          core_clk,
  input wire logic          nrst,
  input asc_pkg::asc_req_s  req,
  input wire logic          req_ready,
  input wire logic          rd_valid,
  input asc_pkg::asc_pins_s mem_pins
);
  import asc_pkg::*;
  wire        c = mem_pins.cs_n;
  wire        w = mem_pins.we_n;
  wire        o = mem_pins.oe_n;
  wire [3:0]  e = mem_pins.data_oe;
  wire [19:0] a = mem_pins.word_address;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence take_rd;
    req.valid && req_ready && !req.write;
  endsequence
  rd_lat_a: assert property (take_rd |-> ##2 rd_valid) else $error("late");
  rd_busy_a: assert property (take_rd |=> !req_ready [*2]) else $error("busy");
  rd_strobe_a: assert property (!o |-> w) else $error("strobe");
  no_fight_a: assert property (!o |-> e == 4'h0) else $error("contention");
  wr_sel_a: assert property (!w |-> !c) else $error("select");
  addr_hold_a: assert property (!c && !$past(c) |-> $stable(a)) else $error("addr");
  wr_pulse_a: assert property ($fell(w) |-> o ##1 w) else $error("pulse");
  drive_gate_a: assert property (e != 4'h0 |-> o) else $error("drive");
  wr_data_a: assert property ($rose(w) |-> e == 4'hF && $past(e) == 4'hF) else $error("data");
  no_poll_a: assert property (req_ready && !req.valid |=> c) else $error("idle");
endmodule : asc_chk
bind asc_ctrl asc_chk chk (.core_clk, .nrst, .req, .req_ready, .rd_valid, .mem_pins);

// [sim/asc_mem.sv]
// behavioural model of the static memory
`timescale 1ns/1ps
module asc_mem (
  input wire logic          core_clk,
  input asc_pkg::asc_pins_s p,
  output logic [3:0]        bus
);
  import asc_pkg::*;
  logic [3:0] m [1048576];
  logic [3:0] lv = 4'h0;
  logic       wr = 1'b0;
  wire        rd = !p.cs_n && !p.oe_n && p.we_n;
  // released lines flip each cycle so a stale value never passes
  always @* begin
    for (int i = 0; i < 4; i++) begin
      bus[i] = p.data_oe[i] ? p.data_out[i] : rd ? m[p.word_address][i] : ~lv[i];
    end
  end
  always @(posedge core_clk) lv <= bus;
  always @(p.cs_n, p.we_n) begin
    if (wr && (p.cs_n || p.we_n)) m[p.word_address] = bus;
    wr = !p.cs_n && !p.we_n;
  end
endmodule : asc_mem

// [sim/testbench.sv]
// self-checking bench for the memory controller
`timescale 1ns/1ps
module testbench;
  import asc_pkg::*;
  logic       core_clk = 1'b0;
  logic       nrst = 1'b0;
  asc_req_s   req = '0;
  logic       req_ready;
  logic       rd_valid;
  logic [3:0] rd_data;
  logic [3:0] lines;
  asc_pins_s  pins;
  int         errors = 0;
  int         checks = 0;
  int         cyc = 0;
  // write bit, address, data; boundary addresses and an overwrite
  logic [24:0] rows [8] = '{25'h100000A, 25'h1FFFFF5, 25'h1555553, 25'h155555C,
                            25'h000000A, 25'h0FFFFF5, 25'h055555C, 25'h000000A};
  asc_ctrl uut (.core_clk, .nrst, .req, .req_ready, .rd_data, .rd_valid,
                .mem_pins(pins), .shared_data_lines_in(lines));
  asc_mem mem (.core_clk, .p(pins), .bus(lines));
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      conclude();
    end
  end
  task conclude;
    if (errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  task chk(input logic [3:0] seen, input logic [3:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task op(input logic [24:0] r);
    @(posedge core_clk) #1 req = {1'b1, r};
    while (req_ready !== 1'b1) @(posedge core_clk) #1;
    @(posedge core_clk) #1 req.valid = 1'b0;
    if (!r[24]) begin
      @(posedge core_clk) #1;
      chk({3'h0, rd_valid}, 4'h1);
      chk(rd_data, r[3:0]);
    end
  endtask : op
  initial begin
    repeat (12) @(posedge core_clk);
    #1 nrst = 1'b1;
    chk({pins.cs_n, pins.we_n, pins.oe_n, req_ready}, 4'hF);
    chk(pins.data_oe, 4'h0);
    foreach (rows[i]) op(rows[i]);
    // reset while selected but before the strobe: no word may change
    @(posedge core_clk) #1 req = {1'b1, 25'h1000005};
    @(posedge core_clk) #1 req.valid = 1'b0;
    chk({2'h0, pins.cs_n, pins.we_n}, 4'h1);
    nrst = 1'b0;
    #1 chk({pins.cs_n, pins.we_n, pins.oe_n, req_ready}, 4'hF);
    chk(pins.data_oe, 4'h0);
    @(posedge core_clk) #1 nrst = 1'b1;
    op(25'h000000A);
    conclude();
  end
endmodule : testbench
